// File: pkg/mtwsc_pkg.sv
// Package: constants, bus carriers and state types of the two-wire channel
package mtwsc_pkg;

	// Register byte addresses on the bus
	localparam logic [7:0] ADR_SHIFT = 8'h00;
	localparam logic [7:0] ADR_SVA   = 8'h04;
	localparam logic [7:0] ADR_CTRL  = 8'h08;
	localparam logic [7:0] ADR_FLAG  = 8'h0C;
	localparam logic [7:0] ADR_STAT  = 8'h10;
	localparam logic [7:0] ADR_PRESC = 8'h14;

	// Control register bit positions
	localparam int CTL_EN   = 7;
	localparam int CTL_LREL = 6;
	localparam int CTL_WREL = 5;
	localparam int CTL_SPIE = 4;
	localparam int CTL_WTIM = 3;
	localparam int CTL_ACKE = 2;
	localparam int CTL_STT  = 1;
	localparam int CTL_SPT  = 0;

	// Flag register bit positions
	localparam int FLG_STCF = 7;
	localparam int FLG_BUSY = 6;
	localparam int FLG_RSV  = 0;

	// Reset values
	localparam logic [7:0] RST_SHIFT = 8'h00;
	localparam logic [7:0] RST_SVA   = 8'h00;
	localparam logic [2:0] RST_PRESC = 3'h0;

	// Prescaler: field value 0..4 divides the main clock by 1..5
	localparam logic [2:0] PRESC_MAX = 3'h4;

	// Timing: data hold after the clock falls, in main-clock cycles
	localparam int CLK_PERIOD_NS = 10;
	localparam int HOLD_TIME_NS  = 300;
	localparam logic [4:0] HOLD_CYC =
		5'((HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// Half of the master clock period, in sampling ticks
	localparam logic [4:0] SCL_HALF_TICKS = 5'h19;

	// Address prefix of extension codes
	localparam logic [4:0] EXT_CODE = 5'h1E;

	// Bus request from the master and answer from the slave
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} mtwsc_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} mtwsc_wb_rsp_t;

	// Master sequencer phases
	typedef enum logic [3:0] {
		MPH_IDLE  = 4'h1,
		MPH_START = 4'h2,
		MPH_RUN   = 4'h4,
		MPH_STOP  = 4'h8
	} mtwsc_mph_t;

	// Complete state of the channel
	typedef struct packed {
		logic        ack;
		logic [31:0] rdat;
		logic [7:0]  shreg;
		logic [7:0]  sva;
		logic        en;
		logic        spie;
		logic        wtim;
		logic        acke;
		logic        stt;
		logic        spt;
		logic        rsv;
		logic        stcf;
		logic        busy;
		logic        mst;
		logic        ald;
		logic        exc;
		logic        coi;
		logic        trc;
		logic        ackd;
		logic        std;
		logic        spd;
		logic [2:0]  presc;
		logic [2:0]  pcnt;
		logic        tick;
		logic        scl_q;
		logic        sda_q;
		logic [3:0]  bcnt;
		logic        aphase;
		logic        waitst;
		logic        scl_oe_n;
		logic        sda_oe_n;
		logic [4:0]  mcnt;
		logic [4:0]  hcnt;
		logic        hpend;
		mtwsc_mph_t  mph;
		logic        irq;
	} mtwsc_state_t;

endpackage

// File: hdl/mtwsc_channel.sv
// Design: one multimaster two-wire serial channel with a bus slave
// Notes on behaviour
// - With the channel disabled no transfer happens and both lines are free.
// - Bytes of eight bits move over shared clock and data lines, multimaster.
// - As master, send start, address, direction bit, data and stop.
// - As slave, conditions and received bytes are recognised in hardware.
// - Clock and data pins are open drain: pulled low or released only.
// - Eight-bit shift register serves both directions and resets to zero.
// - Writing or reading the shift register lets the next byte proceed.
// - Own slave address register, readable and writable, resets to zero.
// - A latch keeps the level driven on the data pin between updates.
// - Interrupt on own address match and on extension code reception.
// - Count clocks sent and received to know when a byte is complete.
// - Interrupt at eighth or ninth clock fall, chosen by wait timing.
// - Interrupt on stop detection only while stop interrupt is enabled.
// - As master, clock pin is driven from the sampling clock.
// - Data line changes only a hold time after the clock falls.
// - Setting the start request generates a start condition.
// - Reservation disabled and bus busy: ignore start, set start failure.
// - Prescaler picks the sampling clock from the main clock.
// - Setting the stop request generates a stop condition.
// - Bus busy tracked from detected start and stop conditions.
//
// Our own choices: the register offsets and the Wishbone interface to the registers.
module mtwsc_channel (
	input  wire logic                    sys_clk_i,
	input  wire logic                    srst_i,
	input  wire mtwsc_pkg::mtwsc_wb_req_t wb_req_i,
	output      mtwsc_pkg::mtwsc_wb_rsp_t wb_rsp_o,
	input  wire logic                    serial_clock_pin_i,
	output      logic                    serial_clock_pin_o,
	output      logic                    serial_clock_pin_oe_n_o,
	input  wire logic                    serial_data_pin_i,
	output      logic                    serial_data_pin_o,
	output      logic                    serial_data_pin_oe_n_o,
	output      logic                    channel_interrupt_request_o
);
	import mtwsc_pkg::*;

	mtwsc_state_t s_reg;
	mtwsc_state_t s_next;
	logic         scl_rise;
	logic         scl_fall;
	logic         start_det;
	logic         stop_det;
	logic         req_new;
	logic         wr;
	logic         rd;
	logic         wr_ctrl;
	logic         part;
	logic         rel;
	logic [2:0]   div_lim;
	logic [7:0]   abyte;

	// True when the bus address selects the given register
	function automatic logic hit(input logic [7:0] adr,
			input logic [7:0] off);
		hit = (adr == off);
	endfunction

	// Line edges seen against the previous sample
	assign scl_rise  = ~s_reg.scl_q & serial_clock_pin_i;
	assign scl_fall  = s_reg.scl_q & ~serial_clock_pin_i;
	assign start_det = s_reg.en & s_reg.scl_q & serial_clock_pin_i &
		s_reg.sda_q & ~serial_data_pin_i;
	assign stop_det  = s_reg.en & s_reg.scl_q & serial_clock_pin_i &
		~s_reg.sda_q & serial_data_pin_i;

	// Bus strobes; a request counts once, in the cycle before ack
	assign req_new = wb_req_i.cyc & wb_req_i.stb & ~s_reg.ack;
	assign wr      = req_new & wb_req_i.we & wb_req_i.sel[0];
	assign rd      = req_new & ~wb_req_i.we;
	assign wr_ctrl = wr & hit(wb_req_i.adr, ADR_CTRL);
	assign part    = s_reg.mst | s_reg.coi | s_reg.exc;
	assign abyte   = {s_reg.shreg[6:0], serial_data_pin_i};
	// Ratios above five are clamped rather than left undefined
	assign div_lim = (s_reg.presc > PRESC_MAX) ? PRESC_MAX : s_reg.presc;

	// Wait is released by shift register access or the release bit
	// shift access trigger
	assign rel = s_reg.waitst & (
		((wr | rd) & hit(wb_req_i.adr, ADR_SHIFT)) |
		(wr_ctrl & wb_req_i.dat[CTL_WREL]));

	// Next-state logic
	always_comb begin
		s_next       = s_reg;
		s_next.ack   = 1'b0;
		s_next.irq   = 1'b0;
		s_next.tick  = 1'b0;
		s_next.scl_q = serial_clock_pin_i;
		s_next.sda_q = serial_data_pin_i;

		if (s_reg.pcnt >= div_lim) begin
			s_next.pcnt = 3'h0;
			s_next.tick = 1'b1;
		end else begin
			s_next.pcnt = s_reg.pcnt + 3'h1;
		end

		// Bus slave: read mux and answer; unmapped reads give zero
		if (req_new) begin
			s_next.ack  = 1'b1;
			s_next.rdat = 32'h0000_0000;
			if (hit(wb_req_i.adr, ADR_SHIFT)) begin
				s_next.rdat[7:0] = s_reg.shreg;
			end else if (hit(wb_req_i.adr, ADR_SVA)) begin
				s_next.rdat[7:0] = s_reg.sva;
			end else if (hit(wb_req_i.adr, ADR_CTRL)) begin
				s_next.rdat[7:0] = {s_reg.en, 2'b00, s_reg.spie,
					s_reg.wtim, s_reg.acke, s_reg.stt, s_reg.spt};
			end else if (hit(wb_req_i.adr, ADR_FLAG)) begin
				s_next.rdat[7:0] = {s_reg.stcf, s_reg.busy, 5'h00,
					s_reg.rsv};
			end else if (hit(wb_req_i.adr, ADR_STAT)) begin
				s_next.rdat[7:0] = {s_reg.mst, s_reg.ald, s_reg.exc,
					s_reg.coi, s_reg.trc, s_reg.ackd, s_reg.std,
					s_reg.spd};
			end else if (hit(wb_req_i.adr, ADR_PRESC)) begin
				s_next.rdat[2:0] = s_reg.presc;
			end
		end

		// Register writes; unmapped writes are acknowledged and dropped
		if (wr) begin
			if (hit(wb_req_i.adr, ADR_SHIFT)) begin
				s_next.shreg = wb_req_i.dat[7:0];
			end else if (hit(wb_req_i.adr, ADR_SVA)) begin
				s_next.sva = wb_req_i.dat[7:0];
			end else if (hit(wb_req_i.adr, ADR_CTRL)) begin
				s_next.en   = wb_req_i.dat[CTL_EN];
				s_next.spie = wb_req_i.dat[CTL_SPIE];
				s_next.wtim = wb_req_i.dat[CTL_WTIM];
				s_next.acke = wb_req_i.dat[CTL_ACKE];
				s_next.spt  = s_reg.spt | wb_req_i.dat[CTL_SPT];
				if (wb_req_i.dat[CTL_STT]) begin
					if (s_reg.rsv & s_reg.busy) begin
						s_next.stcf = 1'b1;
					end else begin
						s_next.stt = 1'b1;
					end
				end
			end else if (hit(wb_req_i.adr, ADR_FLAG)) begin
				s_next.rsv = wb_req_i.dat[FLG_RSV];
				// Writing zero clears; only a control write can set it
				if (~wb_req_i.dat[FLG_STCF]) begin
					s_next.stcf = 1'b0;
				end
			end else if (hit(wb_req_i.adr, ADR_PRESC)) begin
				s_next.presc = wb_req_i.dat[2:0];
			end
		end

		if (~s_next.en) begin // Start may ride on the enabling write
			// stopped mode: lines free, status cleared
			s_next.scl_oe_n = 1'b1;
			s_next.sda_oe_n = 1'b1;
			s_next.stt      = 1'b0;
			s_next.spt      = 1'b0;
			s_next.stcf     = 1'b0;
			s_next.busy     = 1'b0;
			s_next.mst      = 1'b0;
			s_next.ald      = 1'b0;
			s_next.exc      = 1'b0;
			s_next.coi      = 1'b0;
			s_next.trc      = 1'b0;
			s_next.ackd     = 1'b0;
			s_next.std      = 1'b0;
			s_next.spd      = 1'b0;
			s_next.bcnt     = 4'h0;
			s_next.aphase   = 1'b0;
			s_next.waitst   = 1'b0;
			s_next.hpend    = 1'b0;
			s_next.mph      = MPH_IDLE;
		end else begin
			// bus state from start and stop
			if (start_det) begin
				s_next.busy   = 1'b1;
				s_next.std    = 1'b1;
				s_next.spd    = 1'b0;
				s_next.bcnt   = 4'h0;
				s_next.aphase = 1'b1;
			end
			if (stop_det) begin
				s_next.busy   = 1'b0;
				s_next.spd    = 1'b1;
				s_next.std    = 1'b0;
				s_next.mst    = 1'b0;
				s_next.exc    = 1'b0;
				s_next.coi    = 1'b0;
				s_next.trc    = 1'b0;
				s_next.waitst = 1'b0;
				s_next.irq    = s_reg.spie;
			end

			// count clocks; shift in what the line carries
			if (scl_rise) begin
				if (s_reg.bcnt < 4'h8) begin
					s_next.shreg = abyte;
					s_next.bcnt  = s_reg.bcnt + 4'h1;
					// Lost arbitration: released a one, line was low
					if (s_reg.mst & s_reg.sda_oe_n & ~serial_data_pin_i) begin
						s_next.ald      = 1'b1;
						s_next.mst      = 1'b0;
						s_next.mph      = MPH_IDLE;
						s_next.scl_oe_n = 1'b1;
					end
					if (s_reg.bcnt == 4'h7 & s_reg.aphase & ~s_reg.mst) begin
						if (abyte[7:1] == s_reg.sva[7:1]) begin
							s_next.coi = 1'b1;
							s_next.irq = 1'b1;
						end
						if (abyte[7:3] == EXT_CODE) begin
							s_next.exc = 1'b1;
							s_next.irq = 1'b1;
						end
					end
				end else if (s_reg.bcnt == 4'h8) begin
					s_next.bcnt = 4'h9;
					if (s_reg.trc) begin
						s_next.ackd = ~serial_data_pin_i;
					end
				end
			end

			if (scl_fall) begin
				if (s_reg.bcnt == 4'h9) begin
					s_next.bcnt = 4'h0;
					// Direction takes effect once the address byte ends
					if (s_reg.aphase) begin
						s_next.aphase = 1'b0;
						s_next.trc = s_reg.mst ? ~s_reg.shreg[0] :
							s_reg.shreg[0];
					end
				end
				// eighth or ninth fall, per wait timing
				if (part & ((s_reg.bcnt == 4'h8 & ~s_reg.wtim) |
						(s_reg.bcnt == 4'h9 & s_reg.wtim))) begin
					s_next.irq      = 1'b1;
					s_next.waitst   = 1'b1;
					s_next.scl_oe_n = 1'b0;
				end
				s_next.hcnt  = HOLD_CYC;
				s_next.hpend = 1'b1;
			end

			// Leaving the wait restarts the data hold timer
			if (rel) begin
				s_next.waitst = 1'b0;
				s_next.hcnt   = HOLD_CYC;
				s_next.hpend  = 1'b1;
				if (~s_reg.mst) begin
					s_next.scl_oe_n = 1'b1;
				end
			end

			// data changes after the hold time
			if (s_reg.hpend & ~scl_fall & ~rel) begin
				if (s_reg.hcnt != 5'h00) begin
					s_next.hcnt = s_reg.hcnt - 5'h01;
				end else if (s_reg.mph == MPH_RUN | s_reg.mph == MPH_IDLE) begin
					s_next.hpend = 1'b0;
					if (~part | s_reg.bcnt == 4'h9) begin
						s_next.sda_oe_n = 1'b1;
					end else if (s_reg.bcnt == 4'h8) begin
						s_next.sda_oe_n = ~(s_reg.acke & ~s_reg.trc);
					end else begin
						s_next.sda_oe_n = ~(s_reg.trc & ~s_reg.shreg[7]);
					end
				end else begin
					s_next.hpend = 1'b0;
				end
			end

			// Exit from communication: back to standby, lines free
			if (wr_ctrl & wb_req_i.dat[CTL_LREL]) begin
				s_next.scl_oe_n = 1'b1;
				s_next.sda_oe_n = 1'b1;
				s_next.stt      = 1'b0;
				s_next.spt      = 1'b0;
				s_next.mst      = 1'b0;
				s_next.exc      = 1'b0;
				s_next.coi      = 1'b0;
				s_next.trc      = 1'b0;
				s_next.ackd     = 1'b0;
				s_next.std      = 1'b0;
				s_next.waitst   = 1'b0;
				s_next.hpend    = 1'b0;
				s_next.mph      = MPH_IDLE;
			end else begin
				case (s_reg.mph)
					MPH_IDLE: begin
						s_next.spt = 1'b0;
						if (s_reg.stt & ~s_reg.busy) begin
							s_next.mph      = MPH_START;
							s_next.sda_oe_n = 1'b0;
							s_next.mcnt     = 5'h00;
						end
					end
					MPH_START: begin
						if (s_reg.tick) begin
							s_next.mcnt = s_reg.mcnt + 5'h01;
						end
						// Hold clock low and wait for the address byte
						if (s_reg.tick & s_reg.mcnt == SCL_HALF_TICKS) begin
							s_next.scl_oe_n = 1'b0;
							s_next.mph      = MPH_RUN;
							s_next.mst      = 1'b1;
							s_next.trc      = 1'b1;
							s_next.stt      = 1'b0;
							s_next.waitst   = 1'b1;
							s_next.mcnt     = 5'h00;
						end
					end
					MPH_RUN: begin
						if (s_reg.spt & ~s_reg.scl_oe_n & ~s_reg.hpend) begin
							s_next.mph      = MPH_STOP;
							s_next.waitst   = 1'b0;
							s_next.sda_oe_n = 1'b0;
							s_next.mcnt     = 5'h00;
						end else if (~s_reg.waitst & s_reg.tick &
								~s_reg.hpend) begin // No rise inside the hold
							// clock from sampling ticks, stretch aware
							if (~s_reg.scl_oe_n | serial_clock_pin_i) begin
								if (s_reg.mcnt == SCL_HALF_TICKS - 5'h01) begin
									s_next.scl_oe_n = ~s_reg.scl_oe_n;
									s_next.mcnt     = 5'h00;
								end else begin
									s_next.mcnt = s_reg.mcnt + 5'h01;
								end
							end
						end
					end
					MPH_STOP: begin
						if (s_reg.tick) begin
							if (s_reg.mcnt == SCL_HALF_TICKS - 5'h01) begin
								s_next.mcnt = 5'h00;
								if (~s_reg.scl_oe_n) begin
									s_next.scl_oe_n = 1'b1;
								end else if (serial_clock_pin_i) begin
									s_next.sda_oe_n = 1'b1;
									s_next.spt      = 1'b0;
									s_next.mph      = MPH_IDLE;
								end
							end else begin
								s_next.mcnt = s_reg.mcnt + 5'h01;
							end
						end
					end
					default: begin
						s_next.mph = MPH_IDLE;
					end
				endcase
			end
		end
	end

	// State register; reset zeroes it but sets line samples and output enables high and the phase to MPH_IDLE
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			s_reg          <= '0;
			s_reg.shreg    <= RST_SHIFT;
			s_reg.sva      <= RST_SVA;
			s_reg.presc    <= RST_PRESC;
			s_reg.scl_q    <= 1'b1;
			s_reg.sda_q    <= 1'b1;
			s_reg.scl_oe_n <= 1'b1;
			s_reg.sda_oe_n <= 1'b1;
			s_reg.mph      <= MPH_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	// open drain: the level is always low, only the enable moves
	assign serial_clock_pin_o          = 1'b0;
	assign serial_data_pin_o           = 1'b0;
	assign serial_clock_pin_oe_n_o     = s_reg.scl_oe_n;
	assign serial_data_pin_oe_n_o      = s_reg.sda_oe_n;
	assign channel_interrupt_request_o = s_reg.irq;
	assign wb_rsp_o.ack                = s_reg.ack;
	assign wb_rsp_o.dat                = s_reg.rdat;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);

	sequence seq_stt_on_busy;
		wr_ctrl && wb_req_i.dat[CTL_STT] && s_reg.rsv && s_reg.busy;
	endsequence
	sequence seq_stop_seen;
		stop_det && s_reg.spie;
	endsequence

	AST_STOPPED_QUIET: assert property (
		!s_reg.en |=> serial_clock_pin_oe_n_o && serial_data_pin_oe_n_o)
		else $error("lines driven while channel stopped");
	AST_OPEN_DRAIN: assert property (
		!serial_clock_pin_o && !serial_data_pin_o)
		else $error("pin driven high");
	AST_RESET_VALUES: assert property (
		@(posedge sys_clk_i) disable iff (1'b0)
		srst_i |=> s_reg.shreg == RST_SHIFT && s_reg.sva == RST_SVA)
		else $error("shift or address register not zero after reset");
	AST_START_REFUSED: assert property (
		seq_stt_on_busy |=> s_reg.stcf && !s_reg.stt && wb_rsp_o.ack)
		else $error("start on busy bus not refused");
	AST_STOP_IRQ: assert property (
		seq_stop_seen |=> channel_interrupt_request_o && !s_reg.busy)
		else $error("stop interrupt missing");
	AST_WAIT_RELEASE: assert property (
		rel |=> !s_reg.waitst ##1 !s_reg.waitst || scl_fall)
		else $error("shift access did not end the wait");
	AST_BUSY_SET: assert property (
		start_det && !stop_det |=> s_reg.busy && s_reg.std)
		else $error("start did not mark bus busy");
	AST_TICK_DIV5: assert property (
		s_reg.tick && s_reg.presc == PRESC_MAX && $stable(s_reg.presc)
		|-> $past(s_reg.pcnt) == PRESC_MAX)
		else $error("divide by five tick came early");
	AST_HOLD_TIME: assert property (
		scl_fall && s_reg.en |=> $stable(serial_data_pin_oe_n_o) [*2])
		else $error("data changed inside hold time");
	AST_BYTE_IRQ: assert property (
		scl_fall && part && s_reg.en && !stop_det && !rel &&
		s_reg.bcnt == 4'h8 && !s_reg.wtim
		|=> channel_interrupt_request_o && !serial_clock_pin_oe_n_o)
		else $error("eighth clock interrupt or wait missing");
endmodule

// File: dv/mtwsc_bus_partner.sv
// Bus partner: slave that acknowledges its address, and a bit-banging master
module mtwsc_bus_partner #(
	parameter logic [7:0] SLAVE_ADR = 8'hA4,
	parameter int         HALF      = 60
) (
	input  wire logic sys_clk_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output      logic scl_rel_o,
	output      logic sda_rel_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       slave_en, first, addressed;
	logic       start_seen, stop_seen, ack_seen;
	logic       scl_q, sda_q;
	logic [7:0] sh, rx_byte;
	logic [3:0] bits;
	logic [4:0] rise_cnt;

	// Lines start released; pull-ups lift them
	initial begin
		{scl_rel_o, sda_rel_o, slave_en, scl_q, sda_q} = 5'h1F;
		{first, addressed, start_seen, stop_seen, ack_seen} = 5'h00;
		{bits, rise_cnt, sh, rx_byte} = 25'h0;
	end

	// Line watcher; conditions count only while the clock line stays high
	always @(posedge sys_clk_i) begin
		scl_q <= scl_i;
		sda_q <= sda_i;
		if (scl_i && scl_q && sda_q && !sda_i) begin
			start_seen <= 1'b1;
			stop_seen <= 1'b0;
			first <= 1'b1;
			bits <= 4'h0;
			rise_cnt <= 5'h00;
		end else if (scl_i && scl_q && !sda_q && sda_i) begin
			stop_seen <= 1'b1;
		end else if (scl_i && !scl_q) begin
			rise_cnt <= rise_cnt + 5'h01;
			if (bits == 4'h8) begin
				ack_seen <= !sda_i;
				if (first)
					addressed <= rx_byte[7:1] == SLAVE_ADR[7:1];
				first <= 1'b0;
				bits <= 4'h0;
			end else begin
				sh <= {sh[6:0], sda_i};
				if (bits == 4'h7)
					rx_byte <= {sh[6:0], sda_i};
				bits <= bits + 4'h1;
			end
		end else if (!scl_i && scl_q && slave_en) begin
			sda_rel_o <= !(bits == 4'h8 &&
				(first ? rx_byte[7:1] == SLAVE_ADR[7:1] : addressed));
		end
	end

	task automatic hold(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask

	// Release the clock; the device may stretch it, so wait for the line
	task automatic rise();
		int n;
		scl_rel_o <= 1'b1;
		for (n = 0; n < 20000 && scl_i !== 1'b1; n++)
			@(posedge sys_clk_i);
		hold(HALF);
	endtask

	// Start, then one byte with a released ninth bit for the device's ack
	task automatic send_frame(input logic [7:0] b);
		int i;
		slave_en = 1'b0;
		sda_rel_o <= 1'b0;
		hold(HALF);
		scl_rel_o <= 1'b0;
		for (i = 0; i < 9; i++) begin
			hold(HALF / 2);
			sda_rel_o <= (i < 8) ? b[7 - i] : 1'b1;
			hold(HALF / 2);
			rise();
			scl_rel_o <= 1'b0;
		end
		hold(2);
		slave_en = 1'b1;
	endtask

	task automatic send_stop();
		hold(HALF / 2);
		sda_rel_o <= 1'b0;
		hold(HALF / 2);
		rise();
		sda_rel_o <= 1'b1;
		hold(HALF);
	endtask
endmodule

// File: dv/tb_top.sv
// Testbench: register bus and two-wire traffic against the bus partner
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import mtwsc_pkg::*;
	logic          sys_clk_i, srst_i;
	mtwsc_wb_req_t req;
	mtwsc_wb_rsp_t rsp;
	logic          scl_o, scl_oe_n, sda_o, sda_oe_n, irq;
	logic          p_scl, p_sda, scl, sda;
	logic [7:0]    q;
	int            errors, check_count, irq_cnt, cyc_cnt, b, n, i;
	logic [7:0]    rst_adr [7] = '{ADR_SHIFT, ADR_SVA, ADR_CTRL,
		ADR_FLAG, ADR_STAT, ADR_PRESC, 8'h18};
	logic [7:0]    sbyte [2] = '{8'hA4, 8'hF0};
	int            sbit [2] = '{4, 5};

	// Wired-AND of both parties on each open-drain line
	assign scl = (scl_oe_n | scl_o) & p_scl;
	assign sda = (sda_oe_n | sda_o) & p_sda;

	mtwsc_channel mtwsc_channel_i (
		.sys_clk_i(sys_clk_i), .srst_i(srst_i),
		.wb_req_i(req), .wb_rsp_o(rsp),
		.serial_clock_pin_i(scl), .serial_clock_pin_o(scl_o),
		.serial_clock_pin_oe_n_o(scl_oe_n),
		.serial_data_pin_i(sda), .serial_data_pin_o(sda_o),
		.serial_data_pin_oe_n_o(sda_oe_n),
		.channel_interrupt_request_o(irq)
	);

	mtwsc_bus_partner mtwsc_bus_partner_i (
		.sys_clk_i(sys_clk_i), .scl_i(scl), .sda_i(sda),
		.scl_rel_o(p_scl), .sda_rel_o(p_sda)
	);

	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// Interrupt is a pulse, so it is counted rather than polled
	always @(posedge sys_clk_i) begin
		if (irq === 1'b1)
			irq_cnt <= irq_cnt + 1;
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 60000) begin
			errors++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Classic cycle: hold the request until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		int k;
		k = 0;
		@(posedge sys_clk_i);
		req <= '{1'b1, 1'b1, w, a, 4'hF, {24'h0, d}};
		do begin
			@(posedge sys_clk_i);
			k++;
		end while (rsp.ack !== 1'b1);
		q = rsp.dat[7:0];
		req <= '0;
		// Registered slave: ack is seen at the second edge
		chk("bus ack wait", 8'h02, 8'(k));
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e,
		input string nm);
		wb(1'b0, a, 8'h00);
		chk(nm, e, q);
	endtask

	task automatic wait_irq();
		for (n = 0; n < 4000 && irq_cnt == b; n++)
			@(posedge sys_clk_i);
		chk("irq arrived", 8'h01, 8'(irq_cnt != b));
	endtask

	initial begin
		srst_i = 1'b1;
		req = '0;
		{errors, check_count, irq_cnt, cyc_cnt} = '0;
		repeat (2) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		foreach (rst_adr[j])
			rd(rst_adr[j], 8'h00, "reset value");
		wb(1'b1, ADR_SVA, 8'h5A);
		rd(ADR_SVA, 8'h5A, "slave address");
		wb(1'b1, ADR_PRESC, 8'h04);
		rd(ADR_PRESC, 8'h04, "prescaler");
		// Let the divide by five run a few ticks
		repeat (8) @(posedge sys_clk_i);
		wb(1'b1, ADR_PRESC, 8'h00);
		wb(1'b1, 8'h18, 8'hFF);
		rd(8'h18, 8'h00, "unmapped");
		// Start request while stopped must leave the bus untouched
		wb(1'b1, ADR_CTRL, 8'h02);
		repeat (200) @(posedge sys_clk_i);
		chk("released", 8'h03, {6'h0, scl_oe_n, sda_oe_n});
		chk("start", 8'h00, {7'h0, mtwsc_bus_partner_i.start_seen});
		wb(1'b1, ADR_CTRL, 8'h00);
		// Master write: address byte waits at the eighth fall
		b = irq_cnt;
		wb(1'b1, ADR_CTRL, 8'h82);
		for (n = 0; n < 500 && !mtwsc_bus_partner_i.start_seen; n++)
			@(posedge sys_clk_i);
		// Master flag and wait come half a clock after the start
		repeat (40) @(posedge sys_clk_i);
		wb(1'b0, ADR_STAT, 8'h00);
		chk("master", 8'h01, {7'h0, q[7]});
		wb(1'b1, ADR_SHIFT, 8'hA4);
		wait_irq();
		chk("rises", 8'h08, 8'(mtwsc_bus_partner_i.rise_cnt));
		chk("sent", 8'hA4, mtwsc_bus_partner_i.rx_byte);
		b = irq_cnt;
		wb(1'b1, ADR_CTRL, 8'hA8);
		wait_irq();
		chk("rises", 8'h09, 8'(mtwsc_bus_partner_i.rise_cnt));
		wb(1'b0, ADR_STAT, 8'h00);
		chk("ack detected", 8'h01, {7'h0, q[2]});
		wb(1'b1, ADR_FLAG, 8'h01);
		wb(1'b1, ADR_CTRL, 8'h8A);
		rd(ADR_FLAG, 8'hC1, "refused start");
		wb(1'b1, ADR_FLAG, 8'h01);
		rd(ADR_FLAG, 8'h41, "failure cleared");
		b = irq_cnt;
		wb(1'b1, ADR_SHIFT, 8'h3C);
		wait_irq();
		chk("rises", 8'h12, 8'(mtwsc_bus_partner_i.rise_cnt));
		chk("sent", 8'h3C, mtwsc_bus_partner_i.rx_byte);
		b = irq_cnt;
		wb(1'b1, ADR_CTRL, 8'h89);
		for (n = 0; n < 2000 && !mtwsc_bus_partner_i.stop_seen; n++)
			@(posedge sys_clk_i);
		repeat (10) @(posedge sys_clk_i);
		chk("stop seen", 8'h01, {7'h0, mtwsc_bus_partner_i.stop_seen});
		chk("stop irq off", 8'h00, 8'(irq_cnt - b));
		rd(ADR_FLAG, 8'h01, "bus free");
		chk("pin drive", 8'h00, {6'h0, scl_o, sda_o});
		// Slave: own address, then an extension code, each closed by stop
		wb(1'b1, ADR_SVA, 8'hA4);
		wb(1'b1, ADR_CTRL, 8'h9C);
		for (i = 0; i < 2; i++) begin
			b = irq_cnt;
			mtwsc_bus_partner_i.send_frame(sbyte[i]);
			chk("event irq", 8'h01, 8'(irq_cnt != b));
			chk("ack", 8'h01, {7'h0, mtwsc_bus_partner_i.ack_seen});
			wb(1'b0, ADR_STAT, 8'h00);
			chk("status event", 8'h01, {7'h0, q[sbit[i]]});
			rd(ADR_SHIFT, sbyte[i], "received");
			b = irq_cnt;
			mtwsc_bus_partner_i.send_stop();
			chk("stop irq", 8'h01, 8'(irq_cnt - b));
		end
		final_report();
	end
endmodule
